// *** scb_bridge.sv ***
/*
  scb_bridge: text command interpreter, target access and sampling stream.
  assumes bytes, replies, target requests and frame bytes all move
  by valid/ready on ref_clk_in; a formatter outside renders replies.
*/
// How it works
// - setdevice carries the address low nibble; later register accesses go there.
// - setdevice answers with an echo acknowledgment, then the state.
// - after reset the lowest responding target is selected.
// - start-up probe; with no answer the controller falls back to spi.
// - hex arguments take either case, optional zeros, optional 0x prefix.
// - rreg reads the selected target; ack, register object, state.
// - wreg takes hex register and hex value under the same rules.
// - wreg answers ack, console note of value and register, state.
// - collect interval is a decimal 32-bit count of microseconds.
// - result mask bits pick result types for all channels together.
// - packed target nibbles, first target in bits 3 to 0.
// - target count from one to four.
// - all results of one target are read before the next target.
// - sets start one interval apart, or back to back when slower.
// - each frame opens with a zero marker byte, index, register, length.
// - index is the one-based position in the packed target list.
// - length counts data bytes, sent most significant first.
// - stop ends sampling, acknowledges, reports idle.
// - sampling never writes a target register.
// - unselected result types are never read.
// - register commands are served while sampling runs.
`timescale 1ns/10ps
`default_nettype none
module scb_bridge
  import scb_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // command bytes from the host
  input wire logic cmd_valid_in,
  input wire logic [7:0] cmd_byte_in,
  output logic cmd_ready_out,
  // structured replies
  output logic reply_valid_out,
  output scb_pkg::scb_reply_t reply_out,
  input wire logic reply_ready_in,
  // target transactions
  output logic bus_req_valid_out,
  output scb_pkg::scb_bus_req_t bus_req_out,
  input wire logic bus_req_ready_in,
  input wire logic bus_rsp_valid_in,
  input wire scb_pkg::scb_bus_rsp_t bus_rsp_in,
  // frame stream
  output logic frame_valid_out,
  output logic [7:0] frame_byte_out,
  input wire logic frame_ready_in,
  // status
  output logic spi_mode_out,
  output logic collecting_out,
  output logic [3:0] target_low_nibble_out
);
  import scb_pkg::*;

  typedef enum logic [2:0] {
    S_PROBE = 3'b000, S_PWAIT = 3'b001, S_RX = 3'b010, S_EXEC = 3'b011,
    S_BUS = 3'b100, S_BWAIT = 3'b101, S_REPLY = 3'b110
  } scb_cst_t;
  typedef enum logic [1:0] {
    SM_IDLE = 2'b00, SM_REQ = 2'b01, SM_WAIT = 2'b10, SM_EMIT = 2'b11
  } scb_sst_t;

  function automatic logic [4:0] hex_digit(input logic [7:0] c);
    logic [7:0] l;
    l = c | CH_SP;
    if (c >= CH_0 && c <= CH_9) return {1'b1, c[3:0]};
    if (l >= CH_A && l <= CH_F) return {1'b1, 4'(c[3:0] + 4'h9)};
    return 5'h00;
  endfunction

  function automatic scb_cmd_t kw_decode(input logic [7:0] a,
      input logic [7:0] b, input logic [3:0] n);
    if (a == 8'h73 && b == 8'h65 && n == 4'h9) return CMD_SETDEV;
    if (a == 8'h72 && b == 8'h72 && n == 4'h4) return CMD_RREG;
    if (a == 8'h77 && b == 8'h72 && n == 4'h4) return CMD_WREG;
    if (a == 8'h63 && b == 8'h6f && n == 4'h7) return CMD_COLLECT;
    if (a == 8'h73 && b == 8'h74 && n == 4'h4) return CMD_STOP;
    return CMD_NONE;
  endfunction

  function automatic logic args_ok(input scb_cmd_t c, input logic [2:0] n,
      input logic [3:0][31:0] a, input logic bad);
    logic r;
    r = 1'b0;
    case (c)
      CMD_SETDEV: r = n == 3'h2 && a[0] < 32'h10;
      CMD_RREG: r = n == 3'h2 && a[0] < 32'h100;
      CMD_WREG: r = n == 3'h3 && a[0] < 32'h100 && a[1] < 32'h10000;
      CMD_COLLECT: r = n == 3'h5 && a[1] < 32'h100 && a[2] < 32'h10000 &&
        a[3] != 32'h0 && a[3] <= {29'h0, MAX_TGT};
      CMD_STOP: r = n == 3'h1;
      default: r = 1'b0;
    endcase
    return r && !bad;
  endfunction

  function automatic scb_reply_t mk_reply(input scb_cmd_t c, input logic bad,
      input logic [1:0] step, input logic [3:0][31:0] a,
      input logic [31:0] rsp, input logic coll);
    scb_reply_t r;
    r = '{RP_STATE, c, a[0][7:0], a[0], coll};
    if (bad) r.kind = RP_REJECT;
    else if (step == 2'h0) r.kind = RP_ACK;
    else if (step == 2'h1 && c == CMD_RREG) begin
      r.kind = RP_REG;
      r.value = rsp;
    end else if (step == 2'h1 && c == CMD_WREG) begin
      r.kind = RP_CONSOLE;
      r.value = a[1];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // command parser and executor
  scb_cst_t cst_q, cst_d;
  scb_cmd_t cmd_q, cmd_d;
  logic [7:0] kw0_q, kw0_d, kw1_q, kw1_d;
  logic [3:0] kwlen_q, kwlen_d, sel_q, sel_d, pn_q, pn_d;
  logic [2:0] tok_q, tok_d, cnt_q, cnt_d;
  logic intok_q, intok_d, ndig_q, ndig_d, pfx_q, pfx_d, bad_q, bad_d;
  logic spi_q, spi_d, coll_q, coll_d, cstart_q, cstart_d;
  logic [31:0] cur_q, cur_d, ival_q, ival_d, rsp_q, rsp_d;
  logic [3:0][31:0] args_q, args_d;
  logic [4:0] mask_q, mask_d;
  logic [15:0] nib_q, nib_d;
  logic [1:0] step_q, step_d;
  scb_reply_t rp_q, rp_d;
  logic ok, hexm;
  scb_sst_t sst_q, sst_d;

  assign ok = args_ok(cmd_q, tok_q, args_q, bad_q);
  assign hexm = cmd_q == CMD_RREG || cmd_q == CMD_WREG;

  always_comb begin
    logic [7:0] c;
    logic [4:0] dv;
    logic [35:0] wide;
    logic tend, eol;
    c = cmd_byte_in;
    dv = hex_digit(c);
    wide = hexm ? {cur_q, dv[3:0]} : {4'h0, cur_q} * 36'd10 + {32'h0, dv[3:0]};
    tend = 1'b0;
    eol = c == CH_LF || c == CH_CR;
    cst_d = cst_q; cmd_d = cmd_q; kw0_d = kw0_q; kw1_d = kw1_q;
    kwlen_d = kwlen_q; sel_d = sel_q; pn_d = pn_q; tok_d = tok_q;
    cnt_d = cnt_q; intok_d = intok_q; ndig_d = ndig_q; pfx_d = pfx_q;
    bad_d = bad_q; spi_d = spi_q; coll_d = coll_q; cstart_d = 1'b0;
    cur_d = cur_q; ival_d = ival_q; rsp_d = rsp_q; args_d = args_q;
    mask_d = mask_q; nib_d = nib_q; step_d = step_q; rp_d = rp_q;
    unique case (cst_q)
      S_PROBE: if (bus_req_ready_in) cst_d = S_PWAIT;
      S_PWAIT: if (bus_rsp_valid_in) begin
        if (bus_rsp_in.ack) begin
          sel_d = pn_q;
          cst_d = S_RX;
        end else if (pn_q == PROBE_LAST) begin
          spi_d = 1'b1;
          cst_d = S_RX;
        end else begin
          pn_d = pn_q + 4'h1;
          cst_d = S_PROBE;
        end
      end
      S_RX: if (cmd_valid_in) begin
        if (c == CH_SP || eol) begin
          tend = intok_q;
        end else begin
          intok_d = 1'b1;
          if (tok_q == 3'h0) begin
            if (kwlen_q == 4'h0) kw0_d = c;
            if (kwlen_q == 4'h1) kw1_d = c;
            if (kwlen_q != 4'hf) kwlen_d = kwlen_q + 4'h1;
            if (c < CH_A || c > CH_Z) bad_d = 1'b1;
          end else if (hexm && c == CH_X && !pfx_q && ndig_q &&
              cur_q == 32'h0) begin
            pfx_d = 1'b1;
            ndig_d = 1'b0;
          end else begin
            // hex for register commands, decimal otherwise
            if (!dv[4] || (!hexm && c > CH_9) || wide[35:32] != 4'h0)
              bad_d = 1'b1;
            cur_d = wide[31:0];
            ndig_d = 1'b1;
          end
        end
        if (tend) begin
          if (tok_q == 3'h0) begin
            cmd_d = kw_decode(kw0_q, kw1_q, kwlen_q);
          end else if (tok_q > MAX_TGT || !ndig_q) begin
            bad_d = 1'b1;
          end else begin
            args_d[tok_q[1:0] - 2'h1] = cur_q;
          end
          if (tok_q != 3'h7) tok_d = tok_q + 3'h1;
          intok_d = 1'b0; cur_d = 32'h0; ndig_d = 1'b0; pfx_d = 1'b0;
        end
        if (eol && (intok_q || tok_q != 3'h0)) cst_d = S_EXEC;
      end
      S_EXEC: begin
        // no command takes effect unless the line checked out
        if (ok) begin
          unique case (cmd_q)
            CMD_SETDEV: sel_d = args_q[0][3:0];
            CMD_COLLECT: begin
              coll_d = 1'b1;
              cstart_d = 1'b1;
              ival_d = args_q[0];
              mask_d = args_q[1][4:0];
              nib_d = args_q[2][15:0];
              cnt_d = args_q[3][2:0];
            end
            CMD_STOP: coll_d = 1'b0;
            default: ;
          endcase
        end
        step_d = 2'h0;
        if (ok && hexm) cst_d = S_BUS;
        else begin
          cst_d = S_REPLY;
          rp_d = mk_reply(cmd_q, !ok, 2'h0, args_q, rsp_q, coll_d);
        end
      end
      S_BUS: if (sst_q != SM_WAIT && bus_req_ready_in) cst_d = S_BWAIT;
      S_BWAIT: if (bus_rsp_valid_in) begin
        rsp_d = bus_rsp_in.data;
        cst_d = S_REPLY;
        rp_d = mk_reply(cmd_q, 1'b0, 2'h0, args_q, rsp_q, coll_q);
      end
      S_REPLY: if (reply_ready_in) begin
        if (rp_q.kind == RP_STATE || rp_q.kind == RP_REJECT) begin
          cst_d = S_RX; cmd_d = CMD_NONE; tok_d = 3'h0; kwlen_d = 4'h0;
          bad_d = 1'b0; intok_d = 1'b0; cur_d = 32'h0; ndig_d = 1'b0;
          pfx_d = 1'b0;
        end else begin
          step_d = step_q + 2'h1;
          // register object or console note, then the state
          rp_d = mk_reply(cmd_q, 1'b0, step_d, args_q, rsp_q, coll_q);
        end
      end
      default: cst_d = S_RX;
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cst_q <= S_PROBE; cmd_q <= CMD_NONE; kw0_q <= 8'h00; kw1_q <= 8'h00;
      kwlen_q <= 4'h0; sel_q <= SEL_RST; pn_q <= 4'h0; tok_q <= 3'h0;
      cnt_q <= 3'h1; intok_q <= 1'b0; ndig_q <= 1'b0; pfx_q <= 1'b0;
      bad_q <= 1'b0; spi_q <= 1'b0; coll_q <= 1'b0; cstart_q <= 1'b0;
      cur_q <= 32'h0; ival_q <= 32'h0; rsp_q <= 32'h0; args_q <= '0;
      mask_q <= 5'h00; nib_q <= 16'h0000; step_q <= 2'h0; rp_q <= '0;
    end else begin
      cst_q <= cst_d; cmd_q <= cmd_d; kw0_q <= kw0_d; kw1_q <= kw1_d;
      kwlen_q <= kwlen_d; sel_q <= sel_d; pn_q <= pn_d; tok_q <= tok_d;
      cnt_q <= cnt_d; intok_q <= intok_d; ndig_q <= ndig_d; pfx_q <= pfx_d;
      bad_q <= bad_d; spi_q <= spi_d; coll_q <= coll_d; cstart_q <= cstart_d;
      cur_q <= cur_d; ival_q <= ival_d; rsp_q <= rsp_d; args_q <= args_d;
      mask_q <= mask_d; nib_q <= nib_d; step_q <= step_d; rp_q <= rp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sampler: targets outer, result types middle, channels inner
  logic [3:0] us_q, us_d;
  logic [31:0] el_q, el_d, dat_q, dat_d;
  logic [1:0] tgt_q, tgt_d;
  logic [2:0] res_q, res_d, bi_q, bi_d;
  logic ch_q, ch_d, selb, smp_req, push_v, push, fin_ready;
  logic [7:0] push_data, len, raddr;

  assign selb = mask_q[RES_LAST - res_q];
  assign len = res_q == RES_LAST ? LEN_WIDE : LEN_NARROW;
  assign raddr = (ch_q ? CH_STRIDE : 8'h00) | {5'h00, res_q};
  // commands own the bus first; a set may stretch to let them in
  assign smp_req = sst_q == SM_REQ && coll_q && selb &&
    cst_q != S_BUS && cst_q != S_BWAIT;

  always_comb begin
    logic done;
    done = 1'b0;
    sst_d = sst_q; us_d = us_q; el_d = el_q; dat_d = dat_q; tgt_d = tgt_q;
    res_d = res_q; bi_d = bi_q; ch_d = ch_q; push_v = 1'b0;
    push_data = FRAME_MARKER;
    if (us_q == US_LAST) begin
      us_d = 4'h0;
      if (el_q != 32'hffffffff) el_d = el_q + 32'h1;
    end else us_d = us_q + 4'h1;
    if (cstart_q) el_d = 32'hffffffff;
    unique case (sst_q)
      SM_IDLE: if (coll_q && el_q >= ival_q) begin
        sst_d = SM_REQ;
        el_d = 32'h0; us_d = 4'h0;
        tgt_d = 2'h0; res_d = 3'h0; ch_d = 1'b0;
      end
      SM_REQ: begin
        if (!coll_q) sst_d = SM_IDLE;
        else if (!selb) done = 1'b1;
        else if (smp_req && bus_req_ready_in) sst_d = SM_WAIT;
      end
      SM_WAIT: if (bus_rsp_valid_in) begin
        dat_d = len == LEN_WIDE ? bus_rsp_in.data : bus_rsp_in.data << 16;
        bi_d = 3'h0;
        sst_d = SM_EMIT;
      end
      SM_EMIT: begin
        push_v = 1'b1;
        case (bi_q)
          3'h0: push_data = FRAME_MARKER;
          3'h1: push_data = {6'h00, tgt_q} + 8'h01;
          3'h2: push_data = raddr;
          3'h3: push_data = len;
          default: push_data = dat_q[31:24];
        endcase
        if (fin_ready) begin
          if (bi_q > 3'h3) dat_d = dat_q << 8;
          if ({5'h00, bi_q} == len + 8'h03) done = 1'b1;
          else bi_d = bi_q + 3'h1;
        end
      end
      default: sst_d = SM_IDLE;
    endcase
    if (done) begin
      sst_d = SM_REQ;
      ch_d = !ch_q;
      if (ch_q) begin
        if (res_q != RES_LAST) res_d = res_q + 3'h1;
        else begin
          res_d = 3'h0;
          if ({1'b0, tgt_q} + 3'h1 < cnt_q) tgt_d = tgt_q + 2'h1;
          else sst_d = SM_IDLE;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sst_q <= SM_IDLE; us_q <= 4'h0; el_q <= 32'h0; dat_q <= 32'h0;
      tgt_q <= 2'h0; res_q <= 3'h0; bi_q <= 3'h0; ch_q <= 1'b0;
    end else begin
      sst_q <= sst_d; us_q <= us_d; el_q <= el_d; dat_q <= dat_d;
      tgt_q <= tgt_d; res_q <= res_d; bi_q <= bi_d; ch_q <= ch_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // two-entry frame buffer; a stalled receiver holds the sampler
  logic [1:0][7:0] mem_q, mem_d;
  logic wp_q, wp_d, fp_q, fp_d, pop;
  logic [1:0] fc_q, fc_d;

  assign fin_ready = fc_q != 2'h2;
  assign push = push_v && fin_ready;
  assign pop = frame_valid_out && frame_ready_in;

  always_comb begin
    mem_d = mem_q;
    wp_d = wp_q;
    fp_d = fp_q;
    fc_d = fc_q + {1'b0, push} - {1'b0, pop};
    if (push) begin
      mem_d[wp_q] = push_data;
      wp_d = !wp_q;
    end
    if (pop) fp_d = !fp_q;
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mem_q <= '0; wp_q <= 1'b0; fp_q <= 1'b0; fc_q <= 2'h0;
    end else begin
      mem_q <= mem_d; wp_q <= wp_d; fp_q <= fp_d; fc_q <= fc_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign cmd_ready_out = cst_q == S_RX;
  assign reply_valid_out = cst_q == S_REPLY;
  assign reply_out = rp_q;
  assign frame_valid_out = fc_q != 2'h0;
  assign frame_byte_out = mem_q[fp_q];
  assign spi_mode_out = spi_q;
  assign collecting_out = coll_q;
  assign target_low_nibble_out = sel_q;
  assign bus_req_valid_out = cst_q == S_PROBE || smp_req ||
    (cst_q == S_BUS && sst_q != SM_WAIT);

  always_comb begin
    bus_req_out = '{1'b0, {TGT_HIGH, nib_q[4 * tgt_q +: 4]}, raddr, 16'h0};
    if (cst_q == S_PROBE)
      bus_req_out = '{1'b0, {TGT_HIGH, pn_q}, PROBE_REG, 16'h0};
    else if (cst_q == S_BUS) // only wreg ever writes
      bus_req_out = '{cmd_q == CMD_WREG, {TGT_HIGH, sel_q}, args_q[0][7:0],
        args_q[1][15:0]};
  end

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);

  marker_byte_a: assert property (
    push && bi_q == 3'h0 |-> push_data == FRAME_MARKER)
    else $error("frame marker byte not zero");
  board_index_a: assert property (
    push && bi_q == 3'h1 |-> push_data != 8'h00 &&
    push_data <= {5'h00, cnt_q})
    else $error("frame index not one-based");
  payload_len_a: assert property (
    push && bi_q == 3'h3 && res_q != RES_LAST |-> push_data == LEN_NARROW)
    else $error("payload length wrong");
  unselected_read_a: assert property (
    bus_req_valid_out && cst_q != S_BUS && cst_q != S_PROBE |->
    mask_q[RES_LAST - bus_req_out.reg_addr[2:0]])
    else $error("unselected result read");
  sample_no_write_a: assert property (
    bus_req_valid_out && bus_req_out.write |->
    cst_q == S_BUS && cmd_q == CMD_WREG)
    else $error("write outside wreg");
  sequence reject_kept_s;
    cst_q == S_REPLY && rp_q.kind == RP_REJECT && $stable(sel_q) &&
    $stable(coll_q);
  endsequence
  reject_clean_a: assert property (
    cst_q == S_EXEC && !ok |=> reject_kept_s ##1
    (!bus_req_valid_out || sst_q != SM_IDLE))
    else $error("rejected line changed state");
  stop_idle_a: assert property (
    cst_q == S_EXEC && ok && cmd_q == CMD_STOP |=> !coll_q &&
    rp_q.kind == RP_ACK)
    else $error("stop left sampling on");
  set_pace_a: assert property (
    sst_q == SM_IDLE && sst_d == SM_REQ |-> el_q >= ival_q ##1 el_q == 32'h0)
    else $error("set started early");
  setdevice_a: assert property (
    cst_q == S_EXEC && ok && cmd_q == CMD_SETDEV |=>
    sel_q == args_q[0][3:0] ##1 target_low_nibble_out == sel_q)
    else $error("target nibble not taken");
endmodule
`default_nettype wire

// *** scb_pkg.sv ***
/*
  scb_pkg: constants and types shared by the serial command bridge.
  assumes a 10 MHz controller clock and 7-bit target addresses.
*/
`default_nettype none
package scb_pkg;
  // time base
  localparam int CLK_NS = 100;
  localparam int US_NS = 1000;
  localparam int US_CYC = (US_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] US_LAST = 4'(US_CYC - 1);
  // targets and results
  localparam logic [2:0] TGT_HIGH = 3'h4;
  localparam logic [3:0] SEL_RST = 4'h0;
  localparam logic [3:0] PROBE_LAST = 4'hf;
  localparam logic [7:0] PROBE_REG = 8'h00;
  localparam logic [2:0] MAX_TGT = 3'h4;
  localparam logic [2:0] RES_LAST = 3'h4;
  localparam logic [7:0] CH_STRIDE = 8'h08;
  // frame layout
  localparam logic [7:0] FRAME_MARKER = 8'h00;
  localparam logic [7:0] LEN_WIDE = 8'h04;
  localparam logic [7:0] LEN_NARROW = 8'h02;
  // characters
  localparam logic [7:0] CH_SP = 8'h20;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_X = 8'h78;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CH_A = 8'h61;
  localparam logic [7:0] CH_F = 8'h66;
  localparam logic [7:0] CH_Z = 8'h7a;

  typedef enum logic [2:0] {
    CMD_NONE = 3'b000, CMD_SETDEV = 3'b001, CMD_RREG = 3'b010,
    CMD_WREG = 3'b011, CMD_COLLECT = 3'b100, CMD_STOP = 3'b101
  } scb_cmd_t;

  typedef enum logic [2:0] {
    RP_ACK = 3'b000, RP_REG = 3'b001, RP_CONSOLE = 3'b010,
    RP_STATE = 3'b011, RP_REJECT = 3'b100
  } scb_rkind_t;

  typedef struct packed {
    scb_rkind_t kind;
    scb_cmd_t cmd;
    logic [7:0] reg_addr;
    logic [31:0] value;
    logic collecting;
  } scb_reply_t;

  typedef struct packed {
    logic write;
    logic [6:0] dev;
    logic [7:0] reg_addr;
    logic [15:0] data;
  } scb_bus_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] data;
  } scb_bus_rsp_t;
endpackage
`default_nettype wire

// *** scb_target_model.sv ***
/*
  scb_target_model: current-monitor targets behind the bridge's target bus.
  assumes one outstanding request, held by the bridge until taken.
*/
`timescale 1ns/10ps
`default_nettype none
module scb_target_model
  import scb_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // bench control
  input wire logic [15:0] present_in,
  input wire logic slow_in,
  // target bus
  input wire logic bus_req_valid_in,
  input wire scb_pkg::scb_bus_req_t bus_req_in,
  output logic bus_req_ready_out,
  output logic bus_rsp_valid_out,
  output scb_pkg::scb_bus_rsp_t bus_rsp_out,
  // observation
  output logic [15:0] req_cnt_out,
  output logic [7:0] wr_cnt_out,
  output scb_pkg::scb_bus_req_t last_wr_out
);
  import scb_pkg::*;
  ////////////////////////////////////////
  logic busy_q;
  logic [3:0] wait_q;
  scb_bus_req_t held_q;
  assign bus_req_ready_out = ~busy_q;
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_q <= 1'b0;
      wait_q <= 4'h0;
      held_q <= '0;
      bus_rsp_valid_out <= 1'b0;
      bus_rsp_out <= '0;
      req_cnt_out <= 16'h0;
      wr_cnt_out <= 8'h0;
      last_wr_out <= '0;
    end else begin
      bus_rsp_valid_out <= 1'b0;
      // idle answer lines toggle so a stale value is never mistaken
      bus_rsp_out <= ~bus_rsp_out;
      if (bus_req_valid_in && !busy_q) begin
        busy_q <= 1'b1;
        held_q <= bus_req_in;
        wait_q <= slow_in ? 4'h6 : 4'h0;
        req_cnt_out <= req_cnt_out + 16'h1;
      end else if (busy_q && wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
      end else if (busy_q) begin
        busy_q <= 1'b0;
        bus_rsp_valid_out <= 1'b1;
        // only present targets with the fixed high bits answer
        bus_rsp_out.ack <= present_in[held_q.dev[3:0]] &&
          held_q.dev[6:4] == TGT_HIGH;
        bus_rsp_out.data <= {8'h5a, held_q.reg_addr, 1'b0, held_q.dev,
          held_q.reg_addr};
        if (held_q.write) begin
          wr_cnt_out <= wr_cnt_out + 8'h1;
          last_wr_out <= held_q;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** tb_serial_command_register_bridge.sv ***
/*
  tb_serial_command_register_bridge: self-checking bench for scb_bridge.
  assumes scb_target_model on the target bus with targets at nibbles 3, 5.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_serial_command_register_bridge;
  import scb_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic cmd_valid_in = 1'b0;
  logic [7:0] cmd_byte_in = 8'h00;
  logic reply_ready_in = 1'b1;
  logic frame_ready_in = 1'b1;
  logic slow_in = 1'b0;
  logic [15:0] present_in = 16'h0028;
  logic cmd_ready_out, reply_valid_out, bus_req_valid, bus_req_ready;
  logic bus_rsp_valid, frame_valid_out, spi_mode_out, collecting_out;
  logic [7:0] frame_byte_out, wr_cnt;
  logic [3:0] target_low_nibble_out;
  logic [15:0] req_cnt;
  scb_reply_t reply_out;
  scb_bus_req_t bus_req, last_wr;
  scb_bus_rsp_t bus_rsp;
  int mismatches = 0;
  int n_tests = 0;
  int cyc = 0;
  scb_reply_t rq[$];
  logic [7:0] fq[$];
  int ft[$];
  always #50 ref_clk_in = ~ref_clk_in;
  scb_bridge scb_bridge_inst (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
    .cmd_valid_in(cmd_valid_in), .cmd_byte_in(cmd_byte_in),
    .cmd_ready_out(cmd_ready_out), .reply_valid_out(reply_valid_out),
    .reply_out(reply_out), .reply_ready_in(reply_ready_in),
    .bus_req_valid_out(bus_req_valid), .bus_req_out(bus_req),
    .bus_req_ready_in(bus_req_ready), .bus_rsp_valid_in(bus_rsp_valid),
    .bus_rsp_in(bus_rsp), .frame_valid_out(frame_valid_out),
    .frame_byte_out(frame_byte_out), .frame_ready_in(frame_ready_in),
    .spi_mode_out(spi_mode_out), .collecting_out(collecting_out),
    .target_low_nibble_out(target_low_nibble_out));
  scb_target_model scb_target_model_inst (.ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in), .present_in(present_in), .slow_in(slow_in),
    .bus_req_valid_in(bus_req_valid), .bus_req_in(bus_req),
    .bus_req_ready_out(bus_req_ready), .bus_rsp_valid_out(bus_rsp_valid),
    .bus_rsp_out(bus_rsp), .req_cnt_out(req_cnt), .wr_cnt_out(wr_cnt),
    .last_wr_out(last_wr));
  ////////////////////////////////////////
  always @(posedge ref_clk_in) begin
    cyc <= cyc + 1;
    if (reply_valid_out && reply_ready_in) rq.push_back(reply_out);
    if (frame_valid_out && frame_ready_in) begin
      fq.push_back(frame_byte_out);
      ft.push_back(cyc);
    end
    if (cyc == 20000) begin
      mismatches++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (mismatches == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [31:0] rd(input logic [3:0] n,
    input logic [7:0] a);
    return {8'h5a, a, 1'b0, TGT_HIGH, n, a};
  endfunction
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(negedge ref_clk_in);
      cmd_valid_in = 1'b1;
      cmd_byte_in = s[i];
      @(posedge ref_clk_in);
      while (!cmd_ready_out) @(posedge ref_clk_in);
    end
    @(negedge ref_clk_in);
    cmd_valid_in = 1'b0;
  endtask
  task automatic rep(input scb_rkind_t k, output scb_reply_t r);
    int n;
    n = 0;
    while (rq.size() == 0 && n < 3000) begin
      @(negedge ref_clk_in);
      n++;
    end
    r = (rq.size() != 0) ? rq.pop_front() : scb_reply_t'('x);
    check("reply kind", 32'(r.kind), 32'(k));
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    while (cmd_ready_out !== 1'b1 && n < 2000) begin
      @(negedge ref_clk_in);
      n++;
    end
    check("ready", 32'(cmd_ready_out), 32'h1);
  endtask
  ////////////////////////////////////////
  task automatic t_select();
    scb_reply_t r;
    reply_ready_in = 1'b0;
    send("setdevice 5\n");
    repeat (5) @(negedge ref_clk_in);
    check("reply held", 32'(reply_valid_out), 32'h1);
    reply_ready_in = 1'b1;
    rep(RP_ACK, r);
    check("ack value", r.value, 32'h5);
    rep(RP_STATE, r);
    check("state", 32'(r.collecting), 32'h0);
    check("nibble", 32'(target_low_nibble_out), 32'h5);
  endtask
  task automatic t_read();
    scb_reply_t r;
    string f[3] = '{"rreg 7e\n", "rreg 07E\n", "rreg 0x7E\n"};
    foreach (f[i]) begin
      send(f[i]);
      rep(RP_ACK, r);
      rep(RP_REG, r);
      check("read addr", 32'(r.reg_addr), 32'h7e);
      check("read value", r.value, rd(4'h5, 8'h7e));
      rep(RP_STATE, r);
    end
  endtask
  task automatic t_write();
    scb_reply_t r;
    send("wreg 0x20 0x316F\n");
    rep(RP_ACK, r);
    rep(RP_CONSOLE, r);
    check("console value", r.value, 32'h316f);
    check("console reg", 32'(r.reg_addr), 32'h20);
    rep(RP_STATE, r);
    check("write data", 32'(last_wr.data), 32'h316f);
    check("write dev", 32'(last_wr.dev), 32'h45);
  endtask
  task automatic t_reject();
    scb_reply_t r;
    logic [15:0] n0;
    string b[5] = '{"rreg 0X7e\n", "RREG 7e\n", "setdevice\n",
      "collect 20 26 83 5\n", "rreg 7g\n"};
    n0 = req_cnt;
    foreach (b[i]) begin
      send(b[i]);
      rep(RP_REJECT, r);
    end
    check("no bus request", 32'(req_cnt), 32'(n0));
    check("nibble kept", 32'(target_low_nibble_out), 32'h5);
    check("still idle", 32'(collecting_out), 32'h0);
  endtask
  task automatic t_collect();
    scb_reply_t r;
    logic [7:0] ty[4] = '{8'h0, 8'h1, 8'h3, 8'h4};
    logic [7:0] w0, ra;
    logic [31:0] d;
    int k, n, len;
    w0 = wr_cnt;
    slow_in = 1'b1;
    frame_ready_in = 1'b0;
    send("collect 50 27 83 2\n");
    rep(RP_ACK, r);
    rep(RP_STATE, r);
    check("collecting", 32'(r.collecting), 32'h1);
    repeat (60) @(negedge ref_clk_in);
    frame_ready_in = 1'b1;
    n = 0;
    while (fq.size() < 312 && n < 5000) begin
      @(negedge ref_clk_in);
      n++;
    end
    send("rreg 7e\n");
    rep(RP_ACK, r);
    rep(RP_REG, r);
    check("busy read", r.value, rd(4'h5, 8'h7e));
    rep(RP_STATE, r);
    send("stop\n");
    rep(RP_ACK, r);
    rep(RP_STATE, r);
    check("stopped", 32'(r.collecting), 32'h0);
    repeat (100) @(negedge ref_clk_in);
    n = fq.size();
    repeat (600) @(negedge ref_clk_in);
    check("no frames after stop", 32'(fq.size()), 32'(n));
    check("no writes", 32'(wr_cnt), 32'(w0));
    k = 0;
    for (int s = 0; s < 3; s++)
      for (int tg = 0; tg < 2; tg++)
        foreach (ty[t])
          for (int ch = 0; ch < 2; ch++) begin
            ra = 8'(ch * 8) + ty[t];
            d = rd(tg != 0 ? 4'h5 : 4'h3, ra);
            len = (ty[t] == 8'h4) ? 4 : 2;
            check("marker", 32'(fq[k]), 32'(FRAME_MARKER));
            check("index", 32'(fq[k+1]), 32'(tg + 1));
            check("register", 32'(fq[k+2]), 32'(ra));
            check("length", 32'(fq[k+3]), 32'(len));
            for (int j = 0; j < len; j++)
              check("data", 32'(fq[k+4+j]), 32'(d[8*(len-1-j) +: 8]));
            k = k + 4 + len;
          end
    n = ft[208] - ft[104];
    check("set spacing", 32'(n >= 495 && n <= 505), 32'h1);
    slow_in = 1'b0;
  endtask
  task automatic t_spi();
    @(negedge ref_clk_in);
    present_in = 16'h0000;
    rst_n_in = 1'b0;
    repeat (20) @(negedge ref_clk_in);
    rst_n_in = 1'b1;
    wait_ready();
    check("spi fallback", 32'(spi_mode_out), 32'h1);
    check("nibble default", 32'(target_low_nibble_out), 32'h0);
  endtask
  initial begin
    repeat (20) @(negedge ref_clk_in);
    rst_n_in = 1'b1;
    wait_ready();
    check("lowest target", 32'(target_low_nibble_out), 32'h3);
    check("i2c kept", 32'(spi_mode_out), 32'h0);
    t_select();
    t_read();
    t_write();
    t_reject();
    t_collect();
    t_spi();
    finish_test();
  end
endmodule
`default_nettype wire
